// ===== dv/fire_contact_model.sv
`default_nettype none
// ****************************************
// fire control contact on the digital inputs
// ****************************************
module fire_contact_model (
    input wire logic closed,
    input wire logic [2:0] other_in,
    output logic [3:0] din
);
    timeunit 1ns;
    timeprecision 1ps;
    // contact sits on input 2; the rest carry unrelated traffic
    // a dry contact has no memory, so the level follows the command
    assign din = {other_in[2], closed, other_in[1:0]};
endmodule
`default_nettype wire

// ===== dv/fire_mode_override_control_tb.sv
`default_nettype none
module fire_mode_override_control_tb;
    import fire_override_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // signals
    // ****************************************
    localparam int HOLD = 4;
    localparam int DELAY = 8;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] rd_val;
    logic [DIN_W-1:0] din;
    logic closed = 1'b0;
    logic [2:0] other_in = 3'h5;
    logic drive_enable = 1'b1;
    trip_t trip_req = '0;
    trip_t trip_out;
    logic override_active;
    logic fixed_speed_sel;
    logic run_force;
    logic auto_reset;
    logic restart;
    logic irq;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [4:0] func_tab [4] = '{5'h0E, 5'h0F, 5'h12, 5'h13};

    fire_contact_model contact (
        .closed(closed),
        .other_in(other_in),
        .din(din)
    );

    fire_mode_override_control #(
        .TRIP_HOLD(HOLD),
        .RESTART_DELAY(DELAY)
    ) dut (
        .clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .din(din),
        .drive_enable(drive_enable), .trip_req(trip_req),
        .trip_out(trip_out), .override_active(override_active),
        .fixed_speed_sel(fixed_speed_sel), .run_force(run_force),
        .auto_reset(auto_reset), .restart(restart), .irq(irq)
    );

    // ****************************************
    // clock, timeout and helpers
    // ****************************************
    initial begin
        forever #2.5 clk = ~clk;
    end

    // ceiling well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        rd_val = rdata;
    endtask

    task automatic set_cfg(input logic [4:0] f, input logic l,
                           input logic [1:0] lg);
        wr_reg(OFS_CONFIG, {24'h0, f, l, lg});
    endtask

    // registered path: allow two edges before looking
    task automatic set_contact(input logic v);
        @(posedge clk);
        closed <= v;
        cyc(2);
        @(negedge clk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        chk("irq", irq, 0);
        wr_reg(8'h20, 32'hFFFF_FFFF);
        rd_reg(8'h20);
        chk("unmapped", rd_val, 0);
        rd_reg(OFS_CONFIG);
        chk("config", rd_val, {24'h0, CFG_RESET});
        rd_reg(OFS_STATUS);
        chk("status", rd_val, 0);
    endtask

    task automatic t_polarity();
        logic exp;
        for (int lg = 0; lg < 4; lg++) begin
            set_cfg(DI_FUNC_FIRST, 1'b0, 2'(lg));
            for (int c = 0; c < 2; c++) begin
                set_contact(1'(c));
                exp = (lg == 0 || lg == 3) ? 1'(c) : !1'(c);
                chk("active", override_active, exp);
                chk("fixed", fixed_speed_sel, exp && lg == 3);
                chk("run_force", run_force, exp);
            end
        end
        set_contact(1'b0);
    endtask

    task automatic t_func();
        for (int i = 0; i < 4; i++) begin
            set_cfg(func_tab[i], 1'b0, LOGIC_CLOSE);
            set_contact(1'b1);
            chk("func", override_active,
                func_tab[i] >= 5'h0F && func_tab[i] <= 5'h12);
            set_contact(1'b0);
        end
    endtask

    task automatic t_latch();
        set_cfg(5'h10, LATCH_ON, LOGIC_CLOSE);
        set_contact(1'b1);
        set_contact(1'b0);
        cyc(5);
        chk("latched", override_active, 1);
        @(posedge clk);
        drive_enable <= 1'b0;
        cyc(2);
        @(negedge clk);
        chk("disabled", override_active, 0);
        @(posedge clk);
        drive_enable <= 1'b1;
    endtask

    task automatic t_trips();
        set_cfg(DI_FUNC_FIRST, 1'b0, LOGIC_CLOSE);
        set_contact(1'b1);
        wr_reg(OFS_IRQ_STAT, 32'hF);
        wr_reg(OFS_IRQ_MASK, 32'h0);
        @(posedge clk);
        trip_req <= trip_t'(SUPPRESS_MASK);
        cyc(2);
        @(negedge clk);
        chk("suppressed", {18'h0, trip_out}, 0);
        chk("irq masked", irq, 0);
        wr_reg(OFS_IRQ_MASK, 32'h8);
        @(negedge clk);
        chk("irq unmasked", irq, 1);
        set_contact(1'b0);
        chk("restored", {18'h0, trip_out}, {18'h0, SUPPRESS_MASK});
        wr_reg(OFS_IRQ_STAT, 32'hF);
        @(negedge clk);
        chk("irq cleared", irq, 0);
        @(posedge clk);
        trip_req <= '0;
    endtask

    // fatal fault: trip, hold, auto reset, delayed restart
    task automatic t_restart();
        int n;
        set_contact(1'b1);
        wr_reg(OFS_IRQ_STAT, 32'hF);
        wr_reg(OFS_IRQ_MASK, 32'h4);
        @(posedge clk);
        trip_req <= trip_t'(14'h0001);
        cyc(2);
        @(negedge clk);
        chk("fatal trip", {18'h0, trip_out}, 1);
        rd_reg(OFS_STATUS);
        chk("tripped", {30'h0, rd_val[4:3]}, 1);
        @(posedge clk);
        trip_req <= '0;
        n = 0;
        while (auto_reset !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk("auto_reset", auto_reset, 1);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (restart !== 1'b1 && n < 100);
        chk("restart gap", n, DELAY + 1);
        chk("still running", run_force, 1);
        rd_reg(OFS_RESTARTS);
        chk("restarts", rd_val, 1);
        chk("irq restart", irq, 1);
        set_contact(1'b0);
    endtask

    // ****************************************
    // main sequence and verdict
    // ****************************************
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        cyc(8);
        reset <= 1'b0;
        t_reset();
        t_polarity();
        t_func();
        t_latch();
        t_trips();
        t_restart();
        wrap_up();
    end
endmodule
`default_nettype wire

// ===== verilog/fire_mode_override_control.sv
`default_nettype none
module fire_mode_override_control
    import fire_override_pkg::*;
#(
    parameter int TRIP_HOLD = TRIP_HOLD_CYC,
    parameter int RESTART_DELAY = RESTART_DELAY_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [fire_override_pkg::ADDR_W-1:0] addr,
    input wire logic [fire_override_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [fire_override_pkg::DATA_W-1:0] rdata,
    input wire logic [fire_override_pkg::DIN_W-1:0] din,
    input wire logic drive_enable,
    input wire fire_override_pkg::trip_t trip_req,
    output fire_override_pkg::trip_t trip_out,
    output logic override_active,
    output logic fixed_speed_sel,
    output logic run_force,
    output logic auto_reset,
    output logic restart,
    output logic irq
);
    import fire_override_pkg::*;

    // ****************************************
    // registers
    // ****************************************
    cfg_t cfg_ff;
    logic [IRQ_W-1:0] irq_stat_ff;
    logic [IRQ_W-1:0] irq_mask_ff;
    logic [15:0] restarts_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic active_ff;
    logic fixed_ff;
    trip_t trip_out_ff;
    logic auto_reset_ff;
    logic restart_ff;
    restart_state_t state_ff;
    logic [CNT_W-1:0] cnt_ff;

    logic func_ok;
    logic pin_closed;
    logic pin_active;
    logic nxt_active;
    logic [TRIP_W-1:0] allow_mask;
    logic [TRIP_W-1:0] fatal_hit;
    logic [IRQ_W-1:0] events;

    // software writes to the config word
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_ff <= CFG_RESET;
        end else if (wr && addr == OFS_CONFIG) begin
            cfg_ff <= wdata[CFG_W-1:0];
        end
    end

    // ****************************************
    // override decode
    // ****************************************
    // function window and input polarity
    assign func_ok = (cfg_ff.di_func >= DI_FUNC_FIRST) &&
                     (cfg_ff.di_func <= DI_FUNC_LAST);
    assign pin_closed = din[DIN_OVERRIDE_IDX];
    always_comb begin
        unique case (cfg_ff.input_logic)
            LOGIC_CLOSE: pin_active = pin_closed;
            LOGIC_OPEN: pin_active = !pin_closed;
            LOGIC_OPEN_FIXED: pin_active = !pin_closed;
            LOGIC_CLOSE_FIXED: pin_active = pin_closed;
        endcase
    end

    // latched mode holds until disable; maintained follows the pin
    always_comb begin
        if (!func_ok) begin
            nxt_active = 1'b0;
        end else if (cfg_ff.latch == LATCH_ON) begin
            // a new pulse wins over a disable in the same cycle
            nxt_active = pin_active ||
                         (active_ff && drive_enable);
        end else begin
            nxt_active = pin_active;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            active_ff <= 1'b0;
            fixed_ff <= 1'b0;
        end else begin
            active_ff <= nxt_active;
            fixed_ff <= nxt_active &&
                        (cfg_ff.input_logic == LOGIC_CLOSE_FIXED);
        end
    end

    assign override_active = active_ff;
    assign fixed_speed_sel = fixed_ff;
    // run is held regardless of suppressed faults
    assign run_force = active_ff;

    // ****************************************
    // trip filtering
    // ****************************************
    // mask drops as soon as the override ends
    assign allow_mask = active_ff ? ~SUPPRESS_MASK
                                  : {TRIP_W{1'b1}};
    assign fatal_hit = trip_req & RESTART_MASK;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            trip_out_ff <= '0;
        end else begin
            trip_out_ff <= trip_req & allow_mask;
        end
    end
    assign trip_out = trip_out_ff;

    // ****************************************
    // auto reset and restart
    // ****************************************
    // sequence is abandoned when the override ends: normal trips latch
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= RS_IDLE;
            cnt_ff <= '0;
            auto_reset_ff <= 1'b0;
            restart_ff <= 1'b0;
        end else begin
            auto_reset_ff <= 1'b0;
            restart_ff <= 1'b0;
            if (!active_ff) begin
                state_ff <= RS_IDLE;
                cnt_ff <= '0;
            end else begin
                unique case (state_ff)
                    RS_IDLE: begin
                        if (|fatal_hit) begin
                            state_ff <= RS_TRIPPED;
                            cnt_ff <= CNT_W'(TRIP_HOLD - 1);
                        end
                    end
                    RS_TRIPPED: begin
                        if (cnt_ff == '0 && !(|fatal_hit)) begin
                            auto_reset_ff <= 1'b1;
                            state_ff <= RS_RESET_WAIT;
                            cnt_ff <= CNT_W'(RESTART_DELAY - 1);
                        end else if (cnt_ff != '0) begin
                            cnt_ff <= cnt_ff - 1'b1;
                        end
                    end
                    RS_RESET_WAIT: begin
                        if (cnt_ff == '0) begin
                            state_ff <= RS_RESTART;
                        end else begin
                            cnt_ff <= cnt_ff - 1'b1;
                        end
                    end
                    RS_RESTART: begin
                        restart_ff <= 1'b1;
                        state_ff <= RS_IDLE;
                    end
                endcase
            end
        end
    end
    assign auto_reset = auto_reset_ff;
    assign restart = restart_ff;

    // restart count, saturating so it never wraps to zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            restarts_ff <= '0;
        end else if (restart_ff && restarts_ff != 16'hFFFF) begin
            restarts_ff <= restarts_ff + 16'h0001;
        end
    end

    // ****************************************
    // interrupts
    // ****************************************
    always_comb begin
        events = '0;
        events[IRQ_ENTER] = nxt_active && !active_ff;
        events[IRQ_LEAVE] = !nxt_active && active_ff;
        events[IRQ_RESTART] = restart_ff;
        events[IRQ_MASKED] = active_ff && |(trip_req & SUPPRESS_MASK);
    end

    // write one clears; a new event in the same cycle wins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_stat_ff <= '0;
        end else if (wr && addr == OFS_IRQ_STAT) begin
            irq_stat_ff <= (irq_stat_ff & ~wdata[IRQ_W-1:0]) | events;
        end else begin
            irq_stat_ff <= irq_stat_ff | events;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_mask_ff <= '0;
        end else if (wr && addr == OFS_IRQ_MASK) begin
            irq_mask_ff <= wdata[IRQ_W-1:0];
        end
    end
    assign irq = |(irq_stat_ff & irq_mask_ff);

    // ****************************************
    // read port
    // ****************************************
    // unmapped addresses read as zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= '0;
            if (rd) begin
                unique case (addr)
                    OFS_CONFIG: rdata_ff[CFG_W-1:0] <= cfg_ff;
                    OFS_STATUS: rdata_ff[4:0] <= {state_ff, pin_active,
                                                  fixed_ff, active_ff};
                    OFS_IRQ_STAT: rdata_ff[IRQ_W-1:0] <= irq_stat_ff;
                    OFS_IRQ_MASK: rdata_ff[IRQ_W-1:0] <= irq_mask_ff;
                    OFS_RESTARTS: rdata_ff[15:0] <= restarts_ff;
                    default: rdata_ff <= '0;
                endcase
            end
        end
    end
    assign rdata = rdata_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_func_gate;
        !func_ok |=> !active_ff;
    endproperty
    a_func_gate: assert property (p_func_gate)
        else $error("override active outside input function window");

    property p_polarity;
        func_ok && cfg_ff.input_logic == LOGIC_OPEN && !pin_closed
            |=> active_ff;
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("open-to-activate input did not enter override");

    property p_maintained_exit;
        func_ok && cfg_ff.latch != LATCH_ON && !pin_active
            |=> !active_ff;
    endproperty
    a_maintained_exit: assert property (p_maintained_exit)
        else $error("maintained override outlived its input");

    property p_latch_hold;
        active_ff && func_ok && cfg_ff.latch == LATCH_ON && drive_enable
            ##0 $stable(cfg_ff) |=> active_ff;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latched override dropped while drive enabled");

    property p_latch_clear;
        func_ok && cfg_ff.latch == LATCH_ON && !drive_enable && !pin_active
            |=> !active_ff;
    endproperty
    a_latch_clear: assert property (p_latch_clear)
        else $error("latched override not cleared by disable");

    property p_fixed_speed;
        fixed_ff |-> active_ff && $past(cfg_ff.input_logic) ==
            LOGIC_CLOSE_FIXED;
    endproperty
    a_fixed_speed: assert property (p_fixed_speed)
        else $error("fixed speed without option 3 override");

    property p_suppress;
        active_ff ##1 active_ff |-> (trip_out & SUPPRESS_MASK) == '0;
    endproperty
    a_suppress: assert property (p_suppress)
        else $error("suppressed trip passed during override");

    property p_restore;
        !active_ff ##0 (trip_req & SUPPRESS_MASK) != '0
            |=> (trip_out & SUPPRESS_MASK) == $past(trip_req & SUPPRESS_MASK);
    endproperty
    a_restore: assert property (p_restore)
        else $error("trip not restored after override");

    property p_fatal_seq;
        state_ff == RS_RESET_WAIT && active_ff && cnt_ff == '0
            ##1 active_ff |=> restart_ff;
    endproperty
    a_fatal_seq: assert property (p_fatal_seq)
        else $error("restart not issued after reset delay");

    property p_fatal_pass;
        (trip_req & RESTART_MASK) != '0
            |=> (trip_out & RESTART_MASK) != '0;
    endproperty
    a_fatal_pass: assert property (p_fatal_pass)
        else $error("power fault did not trip");
endmodule
`default_nettype wire

// ===== verilog/fire_override_pkg.sv
`default_nettype none
package fire_override_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_RESTARTS = 8'h10;

    // ****************************************
    // configuration fields
    // ****************************************
    localparam int CFG_W = 8;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [4:0] DI_FUNC_FIRST = 5'h0F;
    localparam logic [4:0] DI_FUNC_LAST = 5'h12;
    localparam int DIN_W = 4;
    localparam int DIN_OVERRIDE_IDX = 2;
    localparam logic [1:0] LOGIC_CLOSE = 2'h0;
    localparam logic [1:0] LOGIC_OPEN = 2'h1;
    localparam logic [1:0] LOGIC_OPEN_FIXED = 2'h2;
    localparam logic [1:0] LOGIC_CLOSE_FIXED = 2'h3;
    localparam logic LATCH_ON = 1'b1;

    typedef struct packed {
        logic [4:0] di_func;
        logic latch;
        logic [1:0] input_logic;
    } cfg_t;

    // ****************************************
    // protection trips
    // ****************************************
    localparam int TRIP_W = 14;
    typedef struct packed {
        logic heatsink_over_temp_trip;
        logic under_temp_trip;
        logic heatsink_sensor_fault_trip;
        logic external_trip;
        logic current_loop_loss_trip;
        logic phase_imbalance_trip;
        logic input_phase_loss_trip;
        logic comms_loss_trip;
        logic overload_accum_trip;
        logic bus_over_volt_trip;
        logic bus_under_volt_trip;
        logic fast_over_current_trip;
        logic output_over_current_trip;
        logic output_stage_trip;
    } trip_t;
    localparam logic [13:0] SUPPRESS_MASK = 14'h3FE0;
    localparam logic [13:0] RESTART_MASK = 14'h001F;

    // ****************************************
    // interrupt bits and timing
    // ****************************************
    localparam int IRQ_W = 4;
    localparam int IRQ_ENTER = 0;
    localparam int IRQ_LEAVE = 1;
    localparam int IRQ_RESTART = 2;
    localparam int IRQ_MASKED = 3;
    localparam int CLK_PERIOD_NS = 5;
    localparam int TRIP_HOLD_NS = 1000;
    localparam int RESTART_DELAY_NS = 20000;
    localparam int TRIP_HOLD_CYC =
        (TRIP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESTART_DELAY_CYC =
        (RESTART_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 13;

    typedef enum logic [1:0] {
        RS_IDLE,
        RS_TRIPPED,
        RS_RESET_WAIT,
        RS_RESTART
    } restart_state_t;
endpackage
`default_nettype wire
